// >>> common/pfv_pkg.sv
package pfv_pkg;

	// ----------------------------------------------------------------
	// Command codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PFV_CMD_FREQ = 8'h33;
	localparam logic [7:0] PFV_CMD_CFG = 8'hF5;
	localparam int PFV_NUM_THR = 5;
	localparam int PFV_IDX_START = 0;
	localparam int PFV_IDX_STOP = 1;
	localparam int PFV_IDX_OV = 2;
	localparam int PFV_IDX_UV = 3;
	localparam int PFV_IDX_RFILT = 4;
	// Threshold word commands: start, stop, overvoltage, undervoltage, filter.
	localparam logic [7:0] PFV_THR_CMD [0:4] = '{8'h35, 8'h36, 8'h55, 8'h58, 8'hF7};
	localparam logic [15:0] PFV_THR_RST [0:4] = '{16'hCB40, 16'hCB00, 16'hE300, 16'hCB26,
		16'h12EE};
	localparam logic [15:0] PFV_FREQ_RST = 16'hFABC;
	localparam logic [15:0] PFV_FREQ_EXT = 16'h0000;
	localparam int PFV_NUM_FREQ = 15;
	localparam logic [15:0] PFV_FREQ_CODES [0:14] = '{16'h0000, 16'hEB20, 16'hFBE8, 16'hF258,
		16'hF2BC, 16'hF320, 16'hF384, 16'hF3E8, 16'hFA58, 16'hFABC, 16'hFB52, 16'hFBE8,
		16'h023F, 16'h028A, 16'h02EE};
	localparam logic [7:0] PFV_CFG_RST = 8'h10;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PFV_GAIN_2X = 2'b00,
		PFV_GAIN_4X = 2'b01,
		PFV_GAIN_8X = 2'b10,
		PFV_GAIN_RSVD = 2'b11
	} pfv_gain_e;

	typedef struct packed {
		logic shared_fb;
		pfv_gain_e isense_gain;
		logic share_clk_en;
		logic rsvd;
		logic [2:0] phase_sel;
	} pfv_cfg_s;

	typedef struct packed {
		logic [8:0] ch0;
		logic [8:0] ch1;
	} pfv_phase_s;

	typedef struct packed {
		logic start;
		logic stop;
		logic rx_valid;
		logic tx_next;
		logic [7:0] data;
	} pfv_link_ev_s;

	typedef enum logic [2:0] {
		PFV_ST_IDLE = 3'b000,
		PFV_ST_ADDR = 3'b001,
		PFV_ST_WRITE = 3'b010,
		PFV_ST_ACK = 3'b011,
		PFV_ST_ACKHOLD = 3'b100,
		PFV_ST_READ = 3'b101,
		PFV_ST_RACK = 3'b110,
		PFV_ST_RACK2 = 3'b111
	} pfv_state_e;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Phase offsets in degrees for both channels; unlisted codes fall back to 0/180.
	function automatic pfv_phase_s pfv_phase(input logic [2:0] sel);
		case (sel)
			3'h1: return '{9'd90, 9'd270};
			3'h2: return '{9'd0, 9'd240};
			3'h3: return '{9'd0, 9'd120};
			3'h4: return '{9'd120, 9'd240};
			3'h5: return '{9'd60, 9'd240};
			default: return '{9'd0, 9'd180};
		endcase
	endfunction

	// True when the frequency code is one of the listed settings.
	function automatic logic pfv_freq_ok(input logic [15:0] code);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < PFV_NUM_FREQ; i++) begin
			if (code == PFV_FREQ_CODES[i]) begin
				ok = 1'b1;
			end
		end
		return ok;
	endfunction

	// Expands a 5-bit exponent, 11-bit mantissa value to a common fixed-point scale.
	function automatic logic signed [47:0] pfv_l11_fx(input logic [15:0] v);
		logic signed [47:0] m;
		logic [4:0] sh;
		m = 48'(signed'(v[10:0]));
		sh = v[15:11] + 5'h10;
		return m <<< sh;
	endfunction

endpackage

// >>> core/pfv_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser, one pair of flops per bit.
module pfv_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Asynchronous inputs and their synchronised copies.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	if (W < 1) begin : g_bad_width
		$error("pfv_sync: width must be at least one");
	end

	// ----------------------------------------------------------------
	// Per-bit stages
	// ----------------------------------------------------------------
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic meta;
		// The first stage feeds only the second.
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				meta <= 1'b0;
				q_o[b] <= 1'b0;
			end else begin
				meta <= d_i[b];
				q_o[b] <= meta;
			end
		end
	end

endmodule

`default_nettype wire

// >>> core/pfv_smbus_engine.sv
`timescale 1ns/1ps
`default_nettype none

// Bit-level serial slave: start/stop detect, address match, byte shift, acknowledge.
module pfv_smbus_engine
	import pfv_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Synchronised link lines.
	input wire logic scl_i,
	input wire logic sda_i,
	// Byte-level side towards the command logic.
	input wire logic ack_i,
	input wire logic [7:0] tx_data_i,
	output pfv_link_ev_s ev_o,
	output logic sda_oe_n_o
);

	pfv_state_e state;
	logic scl_q;
	logic sda_q;
	logic is_addr;
	logic rw;
	logic [3:0] cnt;
	logic [7:0] shreg;
	logic [7:0] txsh;
	logic start_det;
	logic stop_det;
	logic rise;
	logic fall;
	logic [7:0] next_byte;

	// ----------------------------------------------------------------
	// Line events
	// ----------------------------------------------------------------
	// Start and stop are data edges while the clock line stays high.
	assign start_det = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_det = scl_i & scl_q & ~sda_q & sda_i;
	assign rise = scl_i & ~scl_q;
	assign fall = ~scl_i & scl_q;
	assign next_byte = {shreg[6:0], sda_i};

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	// The data line only ever changes while the clock line is low.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= PFV_ST_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			is_addr <= 1'b0;
			rw <= 1'b0;
			cnt <= 4'h0;
			shreg <= 8'h00;
			txsh <= 8'hFF;
			ev_o <= '0;
			sda_oe_n_o <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			ev_o.start <= start_det;
			ev_o.stop <= stop_det;
			ev_o.rx_valid <= 1'b0;
			ev_o.tx_next <= 1'b0;
			if (start_det) begin
				state <= PFV_ST_ADDR;
				cnt <= 4'h0;
				sda_oe_n_o <= 1'b1;
			end else if (stop_det) begin
				state <= PFV_ST_IDLE;
				sda_oe_n_o <= 1'b1;
			end else begin
				case (state)
					PFV_ST_ADDR, PFV_ST_WRITE: begin
						if (rise) begin
							shreg <= next_byte;
							cnt <= cnt + 4'h1;
							if (cnt == 4'h7) begin
								cnt <= 4'h0;
								is_addr <= (state == PFV_ST_ADDR);
								if (state == PFV_ST_WRITE) begin
									ev_o.rx_valid <= 1'b1;
									ev_o.data <= next_byte;
									state <= PFV_ST_ACK;
								end else if (next_byte[7:1] == DEV_ADDR) begin
									rw <= next_byte[0];
									state <= PFV_ST_ACK;
								end else begin
									state <= PFV_ST_IDLE;
								end
							end
						end
					end
					PFV_ST_ACK: begin
						if (fall) begin
							sda_oe_n_o <= is_addr ? 1'b0 : ~ack_i;
							ev_o.tx_next <= is_addr & rw;
							state <= PFV_ST_ACKHOLD;
						end
					end
					PFV_ST_ACKHOLD, PFV_ST_RACK2: begin
						if (fall) begin
							if (rw) begin
								sda_oe_n_o <= tx_data_i[7];
								txsh <= tx_data_i;
								cnt <= 4'h1;
								state <= PFV_ST_READ;
							end else begin
								sda_oe_n_o <= 1'b1;
								state <= PFV_ST_WRITE;
							end
						end
					end
					PFV_ST_READ: begin
						if (fall) begin
							if (cnt == 4'h8) begin
								sda_oe_n_o <= 1'b1;
								state <= PFV_ST_RACK;
							end else begin
								sda_oe_n_o <= txsh[6];
								txsh <= {txsh[6:0], 1'b0};
								cnt <= cnt + 4'h1;
							end
						end
					end
					PFV_ST_RACK: begin
						// A low bit from the host asks for one more byte.
						if (rise) begin
							if (!sda_i) begin
								ev_o.tx_next <= 1'b1;
								state <= PFV_ST_RACK2;
							end else begin
								state <= PFV_ST_IDLE;
							end
						end
					end
					default: begin
						state <= PFV_ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// >>> core/pfv_pwm_phase_freq_vin_limits.sv
// Function
// - Configuration write accepted only with both channels off; else refuse and flag busy.
// - Configuration bit 7 routes channel 1 feedback from channel 0's node.
// - Configuration bits 6:5 choose input current sense gain 2x, 4x or 8x.
// - Bit 4 set pulls shared clock low while input is below its thresholds.
// - Configuration bits 2:0 pick the two channel phase offsets from the table.
// - Frequency word holds the listed codes; zero picks the external oscillator.
// - Frequency write accepted only when run low or both channels off.
// - A frequency change raises PLL-unlock until the loop locks again.
// - Input at or above the overvoltage level raises the overvoltage fault.
// - Undervoltage warning armed after start threshold and enable, then flags and alerts.
// - Conversion starts once input reaches the start threshold.
// - Conversion stops once input falls to the stop threshold.
// - Filter resistance word stored, zero meaning no filter fitted.
// - Threshold words use 5-bit exponent, 11-bit mantissa encoding.
// - Configuration byte at code F5, read/write, resets to 10h.
// - Frequency word at code 33, read/write, resets to FABCh.
`timescale 1ns/1ps
`default_nettype none

module pfv_pwm_phase_freq_vin_limits
	import pfv_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Serial link, data line is open drain.
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// Channel state: run pins are asynchronous, commanded-on comes from local logic.
	input wire logic [1:0] run_i,
	input wire logic [1:0] ch_cmd_on_i,
	input wire logic pll_locked_i,
	// Input voltage telemetry from the converter.
	input wire logic [15:0] vin_adc_i,
	input wire logic vin_adc_valid_i,
	// Fault housekeeping.
	input wire logic clear_faults_i,
	input wire logic alert_mask_i,
	// Controller settings.
	output logic shared_feedback_select_o,
	output pfv_gain_e isense_gain_o,
	output logic [8:0] phase_ch0_deg_o,
	output logic [8:0] phase_ch1_deg_o,
	output logic [15:0] switching_frequency_o,
	output logic ext_osc_sel_o,
	output logic pll_unlock_o,
	// Shared clock line, open drain.
	output logic share_clk_o,
	output logic share_clk_oe_n_o,
	// Status.
	output logic conversion_enable_o,
	output logic vin_ov_fault_o,
	output logic vin_uv_warn_o,
	output logic status_input_o,
	output logic busy_fault_o,
	output logic alert_oe_n_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic scl_n_s;
	logic sda_n_s;
	logic [1:0] run_s;
	logic pll_locked_s;
	logic pll_locked_q;
	pfv_link_ev_s ev;
	logic ack;
	logic next_ack;
	logic [7:0] cmd;
	logic [1:0] byte_idx;
	logic [7:0] lo_byte;
	logic rd_idx;
	logic [7:0] tx_byte;
	pfv_cfg_s cfg;
	logic [15:0] freq;
	logic [15:0] thr [0:PFV_NUM_THR-1];
	logic [PFV_NUM_THR-1:0] thr_hit;
	logic [2:0] thr_sel;
	logic [15:0] rd_word;
	logic [15:0] freq_full;
	logic cfg_busy;
	logic freq_busy;
	logic data_byte;
	logic cfg_wr;
	logic freq_wr;
	logic freq_ok;
	logic refuse;
	logic signed [47:0] vin_fx;
	logic uv_armed;

	if (DEV_ADDR > 7'h77) begin : g_bad_addr
		$error("pfv_pwm_phase_freq_vin_limits: device address out of range");
	end

	// ----------------------------------------------------------------
	// Link front end
	// ----------------------------------------------------------------
	// Every pin from outside the clock domain passes two flops.
	// Link lines pass inverted, so the flops' reset level matches the idle-high bus.
	pfv_sync #(
		.W(5)
	) u_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.d_i({~scl_i, ~sda_i, run_i, pll_locked_i}),
		.q_o({scl_n_s, sda_n_s, run_s, pll_locked_s})
	);

	pfv_smbus_engine #(
		.DEV_ADDR(DEV_ADDR)
	) u_engine (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.scl_i(~scl_n_s),
		.sda_i(~sda_n_s),
		.ack_i(ack),
		.tx_data_i(tx_byte),
		.ev_o(ev),
		.sda_oe_n_o(sda_oe_n_o)
	);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Either running channel blocks the configuration byte.
	assign cfg_busy = |(run_s & ch_cmd_on_i);
	// Frequency needs run low or both channels commanded off.
	assign freq_busy = (|run_s) & (|ch_cmd_on_i);
	assign data_byte = ev.rx_valid & (byte_idx != 2'h0);
	assign freq_full = {ev.data, lo_byte};
	assign freq_ok = ~freq_busy & pfv_freq_ok(freq_full);
	assign cfg_wr = data_byte & (byte_idx == 2'h1) & (cmd == PFV_CMD_CFG) & ~cfg_busy;
	assign freq_wr = data_byte & (byte_idx == 2'h2) & (cmd == PFV_CMD_FREQ) & freq_ok;
	assign refuse = data_byte & (((cmd == PFV_CMD_CFG) & cfg_busy) |
		((cmd == PFV_CMD_FREQ) & freq_busy));

	// Matches the stored command against each threshold word.
	always_comb begin
		thr_sel = 3'h0;
		for (int i = 0; i < PFV_NUM_THR; i++) begin
			thr_hit[i] = (cmd == PFV_THR_CMD[i]);
			if (thr_hit[i]) begin
				thr_sel = 3'(i);
			end
		end
	end

	// Works out the acknowledge for the byte just received.
	always_comb begin
		next_ack = 1'b0;
		if (byte_idx == 2'h0) begin
			next_ack = (ev.data == PFV_CMD_CFG) | (ev.data == PFV_CMD_FREQ);
			for (int i = 0; i < PFV_NUM_THR; i++) begin
				if (ev.data == PFV_THR_CMD[i]) begin
					next_ack = 1'b1;
				end
			end
		end else if (byte_idx == 2'h1) begin
			if (cmd == PFV_CMD_CFG) begin
				next_ack = ~cfg_busy;
			end else if (cmd == PFV_CMD_FREQ) begin
				next_ack = ~freq_busy;
			end else begin
				next_ack = |thr_hit;
			end
		end else if (byte_idx == 2'h2) begin
			if (cmd == PFV_CMD_FREQ) begin
				next_ack = freq_ok;
			end else begin
				next_ack = (cmd != PFV_CMD_CFG) & (|thr_hit);
			end
		end
	end

	// Tracks command byte, byte position and acknowledge of each write.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd <= 8'h00;
			byte_idx <= 2'h0;
			lo_byte <= 8'h00;
			ack <= 1'b0;
		end else if (ev.start) begin
			byte_idx <= 2'h0;
		end else if (ev.rx_valid) begin
			ack <= next_ack;
			if (byte_idx == 2'h0) begin
				cmd <= ev.data;
			end
			if (byte_idx == 2'h1) begin
				lo_byte <= ev.data;
			end
			if (byte_idx != 2'h3) begin
				byte_idx <= byte_idx + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Stored settings
	// ----------------------------------------------------------------
	// Configuration byte; a refused write keeps the old value.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg <= PFV_CFG_RST;
		end else if (cfg_wr) begin
			cfg <= ev.data;
		end
	end

	// Frequency word, committed on its high byte.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			freq <= PFV_FREQ_RST;
		end else if (freq_wr) begin
			freq <= freq_full;
		end
	end

	// Threshold and filter words, low byte first.
	for (genvar g = 0; g < PFV_NUM_THR; g++) begin : g_thr
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				thr[g] <= PFV_THR_RST[g];
			end else if (data_byte && byte_idx == 2'h2 && thr_hit[g]) begin
				thr[g] <= freq_full;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Selects the word addressed by the last command byte.
	always_comb begin
		if (cmd == PFV_CMD_CFG) begin
			rd_word = {8'h00, cfg};
		end else if (cmd == PFV_CMD_FREQ) begin
			rd_word = freq;
		end else if (|thr_hit) begin
			rd_word = thr[thr_sel];
		end else begin
			rd_word = 16'h0000;
		end
	end

	// Loads the next byte to send; a repeated start restarts at the low byte.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_idx <= 1'b0;
			tx_byte <= 8'hFF;
		end else if (ev.start) begin
			rd_idx <= 1'b0;
		end else if (ev.tx_next) begin
			tx_byte <= rd_idx ? rd_word[15:8] : rd_word[7:0];
			rd_idx <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Controller outputs
	// ----------------------------------------------------------------
	assign sda_o = 1'b0;
	assign share_clk_o = 1'b0;
	assign shared_feedback_select_o = cfg.shared_fb;
	assign isense_gain_o = cfg.isense_gain;
	assign switching_frequency_o = freq;

	// Decodes phase offsets and the external oscillator choice.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_ch0_deg_o <= 9'h000;
			phase_ch1_deg_o <= 9'h0B4;
			ext_osc_sel_o <= 1'b0;
		end else begin
			phase_ch0_deg_o <= pfv_phase(cfg.phase_sel).ch0;
			phase_ch1_deg_o <= pfv_phase(cfg.phase_sel).ch1;
			ext_osc_sel_o <= (freq == PFV_FREQ_EXT);
		end
	end

	// Flags the loop as unlocked after a change until lock is seen again.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pll_locked_q <= 1'b0;
			pll_unlock_o <= 1'b0;
		end else begin
			pll_locked_q <= pll_locked_s;
			if (freq_wr && freq_full != freq) begin
				pll_unlock_o <= 1'b1;
			end else if (pll_locked_s && !pll_locked_q) begin
				pll_unlock_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Input voltage supervision
	// ----------------------------------------------------------------
	assign vin_fx = pfv_l11_fx(vin_adc_i);

	// Start/stop hysteresis on each new measurement.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			conversion_enable_o <= 1'b0;
		end else if (vin_adc_valid_i) begin
			if (vin_fx >= pfv_l11_fx(thr[PFV_IDX_START])) begin
				conversion_enable_o <= 1'b1;
			end else if (vin_fx <= pfv_l11_fx(thr[PFV_IDX_STOP])) begin
				conversion_enable_o <= 1'b0;
			end
		end
	end

	// Shared clock is held low while conversion is not allowed.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			share_clk_oe_n_o <= 1'b1;
		end else begin
			share_clk_oe_n_o <= ~(cfg.share_clk_en & ~conversion_enable_o);
		end
	end

	// Sticky faults and warnings; a new event wins over a clear.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			uv_armed <= 1'b0;
			vin_ov_fault_o <= 1'b0;
			vin_uv_warn_o <= 1'b0;
			busy_fault_o <= 1'b0;
		end else begin
			if (vin_adc_valid_i && (|ch_cmd_on_i) &&
				vin_fx > pfv_l11_fx(thr[PFV_IDX_START])) begin
				uv_armed <= 1'b1;
			end else if (!conversion_enable_o) begin
				uv_armed <= 1'b0;
			end
			if (vin_adc_valid_i && vin_fx >= pfv_l11_fx(thr[PFV_IDX_OV])) begin
				vin_ov_fault_o <= 1'b1;
			end else if (clear_faults_i) begin
				vin_ov_fault_o <= 1'b0;
			end
			if (vin_adc_valid_i && uv_armed && vin_fx < pfv_l11_fx(thr[PFV_IDX_UV])) begin
				vin_uv_warn_o <= 1'b1;
			end else if (clear_faults_i) begin
				vin_uv_warn_o <= 1'b0;
			end
			if (refuse) begin
				busy_fault_o <= 1'b1;
			end else if (clear_faults_i) begin
				busy_fault_o <= 1'b0;
			end
		end
	end

	// Status summary and alert line, alert pulled low unless masked.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_input_o <= 1'b0;
			alert_oe_n_o <= 1'b1;
		end else begin
			status_input_o <= vin_uv_warn_o | vin_ov_fault_o;
			alert_oe_n_o <= ~((vin_uv_warn_o | vin_ov_fault_o | busy_fault_o) &
				~alert_mask_i);
		end
	end

endmodule

`default_nettype wire

// >>> bench/pfv_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Ties the settings and status outputs to the inputs and states that cause them.
module pfv_chk
	import pfv_pkg::*;
(
	// Clock, reset and causes.
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [1:0] run_i,
	input wire logic [1:0] ch_cmd_on_i,
	input wire logic vin_adc_valid_i,
	input wire logic clear_faults_i,
	input wire logic alert_mask_i,
	// Watched outputs.
	input wire logic shared_feedback_select_o,
	input wire pfv_gain_e isense_gain_o,
	input wire logic [8:0] phase_ch0_deg_o,
	input wire logic [8:0] phase_ch1_deg_o,
	input wire logic [15:0] switching_frequency_o,
	input wire logic ext_osc_sel_o,
	input wire logic pll_unlock_o,
	input wire logic share_clk_oe_n_o,
	input wire logic conversion_enable_o,
	input wire logic vin_ov_fault_o,
	input wire logic vin_uv_warn_o,
	input wire logic status_input_o,
	input wire logic busy_fault_o,
	input wire logic alert_oe_n_o
);
	// -------------------------------------------------------------
	// Checks on every clock while out of reset.
	// -------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	cfg_busy_hold_a: assert property (
		(|(run_i & ch_cmd_on_i))[*4] |=> $stable({shared_feedback_select_o, isense_gain_o}))
		else $error("config moved while busy");
	freq_busy_hold_a: assert property (
		(|run_i && |ch_cmd_on_i)[*4] |=> $stable(switching_frequency_o))
		else $error("frequency moved while busy");
	phase_pair_a: assert property ({phase_ch0_deg_o, phase_ch1_deg_o} inside
		{{9'd0, 9'd180}, {9'd90, 9'd270}, {9'd0, 9'd240}, {9'd0, 9'd120}, {9'd120, 9'd240},
		{9'd60, 9'd240}}) else $error("phase pair not in table");
	freq_listed_a: assert property (switching_frequency_o inside {PFV_FREQ_CODES})
		else $error("frequency code not listed");
	ext_osc_a: assert property (ext_osc_sel_o == ($past(switching_frequency_o) == 16'h0000))
		else $error("external oscillator select wrong");
	pll_unlock_a: assert property ($changed(switching_frequency_o) |-> ##[0:2] pll_unlock_o)
		else $error("no unlock after frequency change");
	ov_sticky_a: assert property (vin_ov_fault_o && !clear_faults_i |=> vin_ov_fault_o)
		else $error("overvoltage fault dropped");
	status_in_a: assert property (status_input_o == $past(vin_uv_warn_o | vin_ov_fault_o))
		else $error("input status wrong");
	alert_line_a: assert property (!alert_oe_n_o ==
		$past((vin_uv_warn_o | vin_ov_fault_o | busy_fault_o) & !alert_mask_i))
		else $error("alert wrong");
	conv_cause_a: assert property ($changed(conversion_enable_o) |-> $past(vin_adc_valid_i))
		else $error("conversion changed without a sample");
	share_free_a: assert property (conversion_enable_o ##1 conversion_enable_o |-> share_clk_oe_n_o)
		else $error("shared clock held while converting");
endmodule

`default_nettype wire

// >>> bench/pfv_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Serial host: makes the link clock only within frames and pulls data low.
module pfv_host_model (
	// Link lines.
	output logic scl_o,
	output logic sda_low_o,
	input wire logic sda_i
);
	logic ok_w;
	logic [15:0] rd_w;
	logic r;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// One bit: data changes with the clock low and is sampled 40 ns after the rise, while the clock is high.
	task automatic xbit(input logic b);
		sda_low_o = !b;
		#40 scl_o = 1'b1;
		#40 r = sda_i;
		#40 scl_o = 1'b0;
		#40;
	endtask
	// A byte MSB first, then the acknowledge bit is read back.
	task automatic wbyte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) xbit(d[i]);
		xbit(1'b1);
		ok_w &= !r;
	endtask
	// Start or repeated start: data falls while the clock is high.
	task automatic start;
		sda_low_o = 1'b0;
		#40 scl_o = 1'b1;
		#80 sda_low_o = 1'b1;
		#80 scl_o = 1'b0;
		#40;
	endtask
	// Words go low byte first; reads end with a not-acknowledge and a stop.
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nw, input int nr);
		ok_w = 1'b1;
		start();
		wbyte(8'h80);
		wbyte(cmd);
		for (int i = 0; i < nw; i++) wbyte(wd[8*i+:8]);
		if (nr > 0) begin
			start();
			wbyte(8'h81);
			for (int i = 0; i < nr; i++) begin
				for (int k = 7; k >= 0; k--) begin
					xbit(1'b1);
					rd_w[8*i+k] = r;
				end
				xbit(i == nr - 1);
			end
		end
		sda_low_o = 1'b1;
		#40 scl_o = 1'b1;
		#80 sda_low_o = 1'b0;
		#80;
	endtask
endmodule

`default_nettype wire

// >>> bench/pfv_pwm_phase_freq_vin_limits_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("CHECK FAILED %0t got %h want %h", $time, a, b); end end

module pfv_pwm_phase_freq_vin_limits_tb;
	import pfv_pkg::*;
	logic clk_i = 0, reset_n_i = 0, pll_locked_i = 0, vin_adc_valid_i = 0;
	logic clear_faults_i = 0, alert_mask_i = 0, sda_o, sda_oe_n_o, shared_feedback_select_o;
	logic [1:0] run_i = 0, ch_cmd_on_i = 0;
	logic [15:0] vin_adc_i = 0, switching_frequency_o, v;
	logic [8:0] phase_ch0_deg_o, phase_ch1_deg_o;
	logic ext_osc_sel_o, pll_unlock_o, share_clk_o, share_clk_oe_n_o, conversion_enable_o;
	logic vin_ov_fault_o, vin_uv_warn_o, status_input_o, busy_fault_o, alert_oe_n_o;
	pfv_gain_e isense_gain_o;
	wire logic scl_i, sda_low, sda_i;
	int err_count = 0, num_checks = 0, seed = 32'hfddc;
	assign sda_i = !(sda_low || !sda_oe_n_o);
	pfv_pwm_phase_freq_vin_limits uut (.*);
	pfv_host_model host (.scl_o(scl_i), .sda_low_o(sda_low), .sda_i(sda_i));
	initial forever #4 clk_i = !clk_i;
	// Expected phase pair for a selector code.
	function automatic logic [17:0] ph(input logic [2:0] s);
		case (s)
			3'h1: return {9'd90, 9'd270};
			3'h2: return {9'd0, 9'd240};
			3'h3: return {9'd0, 9'd120};
			3'h4: return {9'd120, 9'd240};
			3'h5: return {9'd60, 9'd240};
			default: return {9'd0, 9'd180};
		endcase
	endfunction
	// One input voltage sample, then time for the flags to settle.
	task automatic vin(input logic [15:0] x);
		@(negedge clk_i);
		vin_adc_i = x;
		vin_adc_valid_i = 1'b1;
		@(negedge clk_i);
		vin_adc_valid_i = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#700000;
		$display("CHECK FAILED %0t timeout", $time);
		err_count++;
		report_and_stop();
	end
	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(negedge clk_i);
		reset_n_i = 1'b1;
		#80;
		for (int i = 0; i < PFV_NUM_THR; i++) begin
			host.xfer(PFV_THR_CMD[i], 0, 0, 2);
			`CHK(host.rd_w, PFV_THR_RST[i])
			v = 16'($random(seed));
			host.xfer(PFV_THR_CMD[i], v, 2, 0);
			host.xfer(PFV_THR_CMD[i], 0, 0, 2);
			`CHK(host.rd_w, v)
			host.xfer(PFV_THR_CMD[i], PFV_THR_RST[i], 2, 0);
		end
		host.xfer(PFV_CMD_CFG, 0, 0, 1);
		`CHK(host.rd_w[7:0], PFV_CFG_RST)
		host.xfer(PFV_CMD_FREQ, 0, 0, 2);
		`CHK(host.rd_w, PFV_FREQ_RST)
		$display("register defaults and threshold words done");
		for (int s = 0; s <= 8; s++) begin
			v = (s == 8) ? 16'(PFV_CFG_RST) : 16'($random(seed)) & 16'h00F8 | 16'(s);
			host.xfer(PFV_CMD_CFG, v, 1, 0);
			`CHK({shared_feedback_select_o, isense_gain_o}, v[7:5])
			`CHK({phase_ch0_deg_o, phase_ch1_deg_o}, ph(v[2:0]))
		end
		$display("configuration fields done");
		run_i = 2'b11;
		ch_cmd_on_i = 2'b11;
		host.xfer(PFV_CMD_CFG, 16'h00A5, 1, 0);
		`CHK(host.ok_w, 1'b0)
		`CHK(busy_fault_o, 1'b1)
		`CHK(phase_ch1_deg_o, 9'd180)
		host.xfer(PFV_CMD_FREQ, 16'hEB20, 2, 0);
		`CHK({host.ok_w, switching_frequency_o}, {1'b0, PFV_FREQ_RST})
		run_i = 2'b00;
		host.xfer(PFV_CMD_FREQ, 16'h1234, 2, 0);
		`CHK(switching_frequency_o, PFV_FREQ_RST)
		$display("busy refusals done");
		for (int i = 0; i < PFV_NUM_FREQ; i++) begin
			host.xfer(PFV_CMD_FREQ, PFV_FREQ_CODES[i], 2, 0);
			`CHK({switching_frequency_o, ext_osc_sel_o}, {PFV_FREQ_CODES[i], i == 0})
			`CHK(pll_unlock_o, 1'b1)
			pll_locked_i = 1'b1;
			repeat (5) @(negedge clk_i);
			`CHK(pll_unlock_o, 1'b0)
			pll_locked_i = 1'b0;
		end
		$display("frequency codes done");
		ch_cmd_on_i = 2'b01;
		clear_faults_i = 1'b1;
		`CHK(share_clk_oe_n_o, 1'b0)
		vin(16'hCA00);
		`CHK(vin_uv_warn_o, 1'b0)
		clear_faults_i = 1'b0;
		vin(16'hCB80);
		`CHK({conversion_enable_o, share_clk_oe_n_o, alert_oe_n_o}, 3'b111)
		vin(16'hCB10);
		`CHK({vin_uv_warn_o, status_input_o, alert_oe_n_o}, 3'b110)
		alert_mask_i = 1'b1;
		vin(16'hE320);
		`CHK({vin_ov_fault_o, alert_oe_n_o}, 2'b11)
		vin(16'hCA00);
		`CHK({conversion_enable_o, share_clk_oe_n_o}, 2'b00)
		$display("input voltage limits done");
		report_and_stop();
	end
endmodule

bind pfv_pwm_phase_freq_vin_limits pfv_chk chk (.*);

`default_nettype wire
